// >>> hdl/clock_ctrl_pkg.sv
// Package: register map, field layout, reset values and timing constants
package clock_ctrl_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses on the plain register port)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_PLL_CONTROL_STATUS = 8'h29;
    localparam logic [7:0] OFF_RC_OSCILLATOR_TRIM = 8'h30;
    localparam logic [7:0] OFF_SYSTEM_CLOCK_DIVIDER = 8'h31;
    localparam logic [7:0] OFF_CORE_CONTROL = 8'h32;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DIV_CHANGE_ENABLE_BIT = 7;
    localparam int PLL_FACTOR_LSB = 2;
    localparam int PLL_ENABLE_BIT = 1;
    localparam int PLL_LOCK_BIT = 0;
    localparam int CORE_PULLUP_OFF_BIT = 4;
    localparam int CORE_RESET_PIN_DISABLE_BIT = 3;
    localparam int CORE_RC_FREQ_SELECT_BIT = 2;
    localparam int CORE_VECTOR_SELECT_BIT = 1;
    localparam int CORE_VECTOR_CHANGE_BIT = 0;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [7:0] TRIM_FACTORY_DEFAULT = 8'h40; // Neutral default
    localparam logic [3:0] DIV_SELECT_FUSE_OFF = 4'h0;
    localparam logic [3:0] DIV_SELECT_FUSE_ON = 4'h3;
    localparam logic [3:0] PLL_FACTOR_RESET = 4'h4;
    localparam logic [3:0] DIV_SELECT_MAX = 4'h8;
    localparam logic [3:0] PLL_FACTOR_MIN = 4'h2;
    localparam logic [3:0] PLL_FACTOR_MAX = 4'h6;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam logic [2:0] DIV_WINDOW_CYCLES = 3'h4;
    localparam logic [7:0] PLL_LOCK_CYCLES = 8'h40; // Lock settle count

endpackage : clock_ctrl_pkg

// >>> hdl/clock_prescaler_pll_control.sv
// Clock prescaler, PLL control, RC trim and core control registers
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps

// Summary of operation
// - Trim register loads factory value at reset
// - Trim code monotonic, 0x00 lowest, 0x7F highest
// - Change enable sets only with others zero
// - Change enable clears after four cycles
// - Rewriting enable neither restarts nor clears window
// - Division select changes only inside open window
// - Division select resets from divide-by-eight fuse
// - Any division code accepted through the sequence
// - Division select sets power-of-two divisor
// - Divided clock enable is an output only; no register in this module uses it
// - Divider bits 6:4 read as zero
// - PLL factor selects multiplier N+2
// - PLL enable starts PLL and RC oscillator
// - PLL enable reads one when PLL clocks system
// - Lock flag sets once PLL has locked
// - PLL register reserved bits read zero
// - Core control bit 3 loads from fuse
// - RC select: zero 8 MHz, one 1 MHz
// - RC frequency select clears when RC disabled
// - Divisor change glitch-free, switches at period boundary
module clock_prescaler_pll_control (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regReadData,
    // Fuse levels, static pins
    input wire logic divideByEightFuse,
    input wire logic clockSelectFuseBit2,
    input wire logic [7:0] factoryTrim,
    // System status from the clock switch logic
    input wire logic pllIsSystemClock,
    input wire logic rcOscRequested,
    input wire logic pllRefLocked,
    // Clock control outputs
    output logic [7:0] trimCode,
    output logic [3:0] pllFactor,
    output logic pllRunning,
    output logic rcOscRunning,
    output logic rcFrequencySelect,
    output logic resetPinDisable,
    output logic systemClockEnable,
    output logic pllClockSafe
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] syncDiv8; // Fuse strap sync
    logic [1:0] syncCksel; // Fuse strap sync
    logic [1:0] syncPllSys; // PLL selected sync
    logic [1:0] syncRcReq; // RC requested sync
    logic [1:0] syncLock; // Lock detector sync
    logic [7:0] trimSyncA; // Factory trim, first stage
    logic [7:0] trimSyncB; // Factory trim, second stage

    // Two flops per asynchronous input
    always_ff @(posedge clk) begin
        if (rst) begin
            syncDiv8 <= 2'h0;
            syncCksel <= 2'h0;
            syncPllSys <= 2'h0;
            syncRcReq <= 2'h0;
            syncLock <= 2'h0;
            trimSyncA <= 8'h00;
            trimSyncB <= 8'h00;
        end else begin
            syncDiv8 <= {syncDiv8[0], divideByEightFuse};
            syncCksel <= {syncCksel[0], clockSelectFuseBit2};
            syncPllSys <= {syncPllSys[0], pllIsSystemClock};
            syncRcReq <= {syncRcReq[0], rcOscRequested};
            syncLock <= {syncLock[0], pllRefLocked};
            trimSyncA <= factoryTrim;
            trimSyncB <= trimSyncA;
        end
    end

    // ------------------------------------------------------------
    // Strap capture after reset release
    // ------------------------------------------------------------
    logic [1:0] strapCount; // Waits for sync chain to fill
    logic strapsLoaded; // Straps applied once

    // Counts two edges after release, then loads straps
    always_ff @(posedge clk) begin
        if (rst) begin
            strapCount <= 2'h0;
            strapsLoaded <= 1'b0;
        end else if (!strapsLoaded) begin
            strapCount <= strapCount + 2'h1;
            if (strapCount == 2'h2)
                strapsLoaded <= 1'b1;
        end
    end

    wire loadStraps = !strapsLoaded && (strapCount == 2'h2);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire wrTrim = regWrite &&
        (regAddr == clock_ctrl_pkg::OFF_RC_OSCILLATOR_TRIM);
    wire wrDiv = regWrite &&
        (regAddr == clock_ctrl_pkg::OFF_SYSTEM_CLOCK_DIVIDER);
    wire wrPll = regWrite &&
        (regAddr == clock_ctrl_pkg::OFF_PLL_CONTROL_STATUS);
    wire wrCore = regWrite &&
        (regAddr == clock_ctrl_pkg::OFF_CORE_CONTROL);

    // ------------------------------------------------------------
    // Oscillator trim
    // ------------------------------------------------------------
    // Trim passes straight to the monotonic RC trim DAC
    always_ff @(posedge clk) begin
        if (rst)
            trimCode <= clock_ctrl_pkg::TRIM_FACTORY_DEFAULT;
        else if (loadStraps)
            trimCode <= trimSyncB;
        else if (wrTrim)
            trimCode <= regWriteData;
    end

    // ------------------------------------------------------------
    // Protected divider change
    // ------------------------------------------------------------
    logic changeEnable; // Window open flag
    logic [2:0] windowCount; // Cycles left in window
    logic [3:0] divisionSelect; // Active division code

    wire enableWrite = wrDiv &&
        regWriteData[clock_ctrl_pkg::DIV_CHANGE_ENABLE_BIT] &&
        (regWriteData[6:0] == 7'h00);
    wire selectWrite = wrDiv &&
        !regWriteData[clock_ctrl_pkg::DIV_CHANGE_ENABLE_BIT];

    // Window opens once, closes on timeout or select write
    always_ff @(posedge clk) begin
        if (rst) begin
            changeEnable <= 1'b0;
            windowCount <= 3'h0;
        end else if (changeEnable) begin
            if (selectWrite || windowCount == 3'h1) begin
                changeEnable <= 1'b0;
                windowCount <= 3'h0;
            end else begin
                windowCount <= windowCount - 3'h1;
            end
        end else if (enableWrite) begin
            changeEnable <= 1'b1;
            windowCount <= clock_ctrl_pkg::DIV_WINDOW_CYCLES;
        end
    end

    // Division code update inside open window only
    always_ff @(posedge clk) begin
        if (rst)
            divisionSelect <= clock_ctrl_pkg::DIV_SELECT_FUSE_OFF;
        else if (loadStraps)
            divisionSelect <= syncDiv8[1] ?
                clock_ctrl_pkg::DIV_SELECT_FUSE_ON :
                clock_ctrl_pkg::DIV_SELECT_FUSE_OFF;
        else if (selectWrite && changeEnable)
            divisionSelect <= regWriteData[3:0];
    end

    // ------------------------------------------------------------
    // Divider producing the system clock enable
    // ------------------------------------------------------------
    // Period in cycles minus one; reserved codes hold at 256
    function automatic logic [7:0] period_of(input logic [3:0] code);
        logic [3:0] c;
        c = (code > clock_ctrl_pkg::DIV_SELECT_MAX) ?
            clock_ctrl_pkg::DIV_SELECT_MAX : code;
        period_of = 8'((9'h001 << c) - 9'h001);
    endfunction

    logic [7:0] divCount; // Cycles within current period
    logic [3:0] appliedSelect; // Code taken at period boundary

    // New code applied only at end of a full period
    always_ff @(posedge clk) begin
        if (rst) begin
            divCount <= 8'h00;
            appliedSelect <= clock_ctrl_pkg::DIV_SELECT_FUSE_OFF;
            systemClockEnable <= 1'b0;
        end else begin
            systemClockEnable <= (divCount == 8'h00);
            if (divCount >= period_of(appliedSelect)) begin
                divCount <= 8'h00;
                appliedSelect <= divisionSelect;
            end else begin
                divCount <= divCount + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // PLL control
    // ------------------------------------------------------------
    logic pllEnableBit; // Software enable
    logic [7:0] lockCount; // Settling counter
    logic pllLocked; // Lock flag

    // Factor and enable written by software
    always_ff @(posedge clk) begin
        if (rst) begin
            pllFactor <= clock_ctrl_pkg::PLL_FACTOR_RESET;
            pllEnableBit <= 1'b0;
        end else if (wrPll) begin
            pllFactor <= regWriteData[5:2];
            pllEnableBit <= regWriteData[clock_ctrl_pkg::PLL_ENABLE_BIT];
        end
    end

    wire pllOn = pllEnableBit || syncPllSys[1];

    // PLL and its RC reference run while enabled
    always_ff @(posedge clk) begin
        if (rst) begin
            pllRunning <= 1'b0;
            rcOscRunning <= 1'b0;
        end else begin
            pllRunning <= pllOn;
            rcOscRunning <= pllOn || syncRcReq[1];
        end
    end

    // Lock once reference locked and settling elapsed
    always_ff @(posedge clk) begin
        if (rst || !pllOn || !syncLock[1]) begin
            lockCount <= 8'h00;
            pllLocked <= 1'b0;
            pllClockSafe <= 1'b0;
        end else if (lockCount == clock_ctrl_pkg::PLL_LOCK_CYCLES) begin
            pllLocked <= 1'b1;
            pllClockSafe <= 1'b1;
        end else begin
            lockCount <= lockCount + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Core control
    // ------------------------------------------------------------
    logic [2:0] coreMisc; // Pull-up off, vector select, vector change

    // Fuse strap, RC select with hardware clear
    always_ff @(posedge clk) begin
        if (rst) begin
            resetPinDisable <= 1'b0;
            rcFrequencySelect <= 1'b0;
            coreMisc <= 3'h0;
        end else begin
            if (loadStraps)
                resetPinDisable <= syncCksel[1];
            else if (wrCore)
                resetPinDisable <= regWriteData[3];
            if (!rcOscRunning)
                rcFrequencySelect <= 1'b0;
            else if (wrCore)
                rcFrequencySelect <= regWriteData[2];
            if (wrCore)
                coreMisc <= {regWriteData[4], regWriteData[1:0]};
        end
    end

    // ------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst)
            regReadData <= 8'h00;
        else if (regRead) begin
            unique case (regAddr)
                clock_ctrl_pkg::OFF_RC_OSCILLATOR_TRIM:
                    regReadData <= trimCode;
                clock_ctrl_pkg::OFF_SYSTEM_CLOCK_DIVIDER:
                    regReadData <= {changeEnable, 3'h0,
                        divisionSelect};
                clock_ctrl_pkg::OFF_PLL_CONTROL_STATUS:
                    regReadData <= {2'h0, pllFactor, pllOn,
                        pllLocked};
                clock_ctrl_pkg::OFF_CORE_CONTROL:
                    regReadData <= {3'h0, coreMisc[2], resetPinDisable,
                        rcFrequencySelect, coreMisc[1:0]};
                default:
                    regReadData <= 8'h00;
            endcase
        end else
            regReadData <= 8'h00;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_window_closes: assert property (@(posedge clk)
        disable iff (rst) $rose(changeEnable) |-> ##[1:4] !changeEnable)
        else $error("change window open too long");
    chk_window_opens_clean: assert property (@(posedge clk)
        disable iff (rst) $rose(changeEnable) |-> $past(enableWrite))
        else $error("window opened without clean enable write");
    chk_rewrite_no_restart: assert property (@(posedge clk)
        disable iff (rst)
        (changeEnable && enableWrite && windowCount > 3'h1)
        |=> changeEnable && windowCount == $past(windowCount) - 3'h1)
        else $error("enable rewrite disturbed window");
    chk_select_guarded: assert property (@(posedge clk)
        disable iff (rst)
        (divisionSelect != $past(divisionSelect) && !$past(loadStraps))
        |-> $past(changeEnable && selectWrite))
        else $error("division changed outside window");
    chk_div_reads_zero: assert property (@(posedge clk)
        disable iff (rst)
        $past(regRead && regAddr == clock_ctrl_pkg::OFF_SYSTEM_CLOCK_DIVIDER)
        |-> regReadData[6:4] == 3'h0)
        else $error("divider reserved bits nonzero");
    // Lock bit compared with the flag as it stood at the strobe
    chk_pll_reserved: assert property (@(posedge clk)
        disable iff (rst)
        $past(regRead && regAddr == clock_ctrl_pkg::OFF_PLL_CONTROL_STATUS)
        |-> regReadData[7:6] == 2'h0 && regReadData[0] == $past(pllLocked))
        else $error("pll register read wrong");
    // Enable output lags the applied code by one cycle
    chk_enable_pulse: assert property (@(posedge clk)
        disable iff (rst)
        systemClockEnable && $past(appliedSelect) == 4'h1
        |=> !systemClockEnable)
        else $error("enable pulse too long for divide two");
    chk_rc_cleared: assert property (@(posedge clk)
        disable iff (rst) !rcOscRunning |=> !rcFrequencySelect)
        else $error("rc select held while oscillator off");
    chk_lock_needs_pll: assert property (@(posedge clk)
        disable iff (rst) pllLocked |-> $past(pllOn))
        else $error("lock without enabled pll");

    // ------------------------------------------------------------
    // Register path checks
    // ------------------------------------------------------------
    // Software trim write lands unless straps load that cycle
    chk_trim_written: assert property (@(posedge clk)
        disable iff (rst)
        wrTrim && !loadStraps |=> trimCode == $past(regWriteData))
        else $error("trim write lost");
    // A dirty enable write leaves the window shut
    chk_enable_dirty: assert property (@(posedge clk)
        disable iff (rst)
        wrDiv && regWriteData[7] && regWriteData[6:0] != 7'h00 &&
        !changeEnable |=> !changeEnable)
        else $error("window opened by dirty write");
    // Strap load picks the fused division code
    chk_strap_division: assert property (@(posedge clk)
        disable iff (rst)
        $past(loadStraps) |-> divisionSelect == ($past(syncDiv8[1]) ?
        clock_ctrl_pkg::DIV_SELECT_FUSE_ON :
        clock_ctrl_pkg::DIV_SELECT_FUSE_OFF))
        else $error("division reset value wrong");
    // Enable bit reads one while the PLL clocks the system
    chk_pll_sys_read: assert property (@(posedge clk)
        disable iff (rst)
        $past(regRead && regAddr == clock_ctrl_pkg::OFF_PLL_CONTROL_STATUS &&
        syncPllSys[1]) |-> regReadData[1])
        else $error("pll enable low while pll clocks");
    // Software enable starts the PLL and its reference
    chk_pll_runs: assert property (@(posedge clk)
        disable iff (rst) pllEnableBit |=> pllRunning && rcOscRunning)
        else $error("pll or reference not started");
    // Frequency select write taken while the RC runs
    chk_rc_select_write: assert property (@(posedge clk)
        disable iff (rst)
        wrCore && rcOscRunning
        |=> rcFrequencySelect == $past(regWriteData[2]))
        else $error("rc select write lost");

endmodule // clock_prescaler_pll_control

// >>> verif/test_clock_prescaler_pll_control.sv
// Self-checking bench for the clock prescaler and PLL control registers
`timescale 1ns/10ps

module test_clock_prescaler_pll_control;

    // ----------------------------------------------------------------
    // Signals and register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] aPll = clock_ctrl_pkg::OFF_PLL_CONTROL_STATUS;
    localparam logic [7:0] aTrim = clock_ctrl_pkg::OFF_RC_OSCILLATOR_TRIM;
    localparam logic [7:0] aDiv = clock_ctrl_pkg::OFF_SYSTEM_CLOCK_DIVIDER;
    localparam logic [7:0] aCore = clock_ctrl_pkg::OFF_CORE_CONTROL;
    logic clk = 1'b0; // 20 MHz system clock
    logic rst = 1'b1; // Synchronous reset, high
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWriteData = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regReadData;
    logic divideByEightFuse = 1'b1; // Strap levels
    logic clockSelectFuseBit2 = 1'b1;
    logic [7:0] factoryTrim = 8'h5a;
    logic pllIsSystemClock = 1'b0; // Clock switch status
    logic rcOscRequested = 1'b0;
    logic pllRefLocked = 1'b0;
    logic [7:0] trimCode;
    logic [3:0] pllFactor;
    logic pllRunning, rcOscRunning, rcFrequencySelect, resetPinDisable;
    logic systemClockEnable, pllClockSafe;
    logic [7:0] rdData; // Last captured read data
    int nMismatch = 0;
    int nCompared = 0;
    int cnt; // Pulse or wait counter
    int expPulses;

    // Device under test
    clock_prescaler_pll_control u_dut (
        .clk(clk), .rst(rst), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite),
        .regRead(regRead), .regReadData(regReadData),
        .divideByEightFuse(divideByEightFuse),
        .clockSelectFuseBit2(clockSelectFuseBit2),
        .factoryTrim(factoryTrim), .pllIsSystemClock(pllIsSystemClock),
        .rcOscRequested(rcOscRequested), .pllRefLocked(pllRefLocked),
        .trimCode(trimCode), .pllFactor(pllFactor),
        .pllRunning(pllRunning), .rcOscRunning(rcOscRunning),
        .rcFrequencySelect(rcFrequencySelect),
        .resetPinDisable(resetPinDisable),
        .systemClockEnable(systemClockEnable), .pllClockSafe(pllClockSafe)
    );

    // Free-running clock, 50 ns period
    initial begin
        forever #25 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Bus tasks and comparisons
    // ----------------------------------------------------------------
    // One bus cycle; strobes stay until the next call overrides them
    task automatic bus(input logic w, input logic r, input logic [7:0] a,
                       input logic [7:0] d);
        regWrite <= w;
        regRead <= r;
        regAddr <= a;
        regWriteData <= d;
        @(posedge clk);
    endtask
    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        bus(1'b0, 1'b1, a, 8'h00);
        #1;
        rdData = regReadData;
        bus(1'b0, 1'b0, 8'h00, 8'h00);
    endtask
    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        nCompared++;
        if (got !== exp) begin
            nMismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkReg(input string what, input logic [7:0] a,
                          input logic [7:0] exp);
        rd(a);
        chk(what, {8'h00, exp}, {8'h00, rdData});
    endtask
    // Reset with given strap levels, then wait past strap loading
    task automatic dutReset(input logic f8, input logic f2,
                            input logic [7:0] t);
        divideByEightFuse <= f8;
        clockSelectFuseBit2 <= f2;
        factoryTrim <= t;
        rst <= 1'b1;
        idle(16);
        rst <= 1'b0;
        idle(5);
    endtask
    // Protected two-write divider change
    task automatic setDiv(input logic [3:0] code);
        wr(aDiv, 8'h80);
        wr(aDiv, {4'h0, code});
        idle(1);
    endtask
    // Count divided-clock enable pulses over n cycles
    task automatic countEnables(input int n);
        cnt = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (systemClockEnable === 1'b1) cnt++;
        end
    endtask
    // Verdict and end of run
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", nCompared, nMismatch);
        if (nMismatch == 0 && nCompared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        // Reset values with both straps set
        dutReset(1'b1, 1'b1, 8'h5a);
        chkReg("trim reset", aTrim, 8'h5a);
        chkReg("divider reset", aDiv, 8'h03);
        chkReg("pll reset", aPll, 8'h10);
        chkReg("core reset", aCore, 8'h08);
        chkReg("unmapped read", 8'h00, 8'h00);
        wr(aTrim, 8'h00);
        idle(1);
        chk("trim low", 16'h0000, {8'h00, trimCode});
        wr(aTrim, 8'h7f);
        idle(1);
        chk("trim high", 16'h007f, {8'h00, trimCode});
        chkReg("trim read", aTrim, 8'h7f);
        $display("test reset_and_trim done");
        // Refused writes and window edges
        wr(aDiv, 8'h85);
        wr(aDiv, 8'h01);
        idle(1);
        chkReg("divider unprotected", aDiv, 8'h03);
        wr(aDiv, 8'h80);
        idle(3);
        wr(aDiv, 8'h01);
        idle(1);
        chkReg("divider last window cycle", aDiv, 8'h01);
        wr(aDiv, 8'h80);
        idle(4);
        wr(aDiv, 8'h02);
        idle(1);
        chkReg("divider window expired", aDiv, 8'h01);
        wr(aDiv, 8'h80);
        wr(aDiv, 8'h80);
        rd(aDiv);
        chk("enable after rewrite", 16'h0081, {8'h00, rdData});
        wr(aDiv, 8'h04);
        idle(1);
        chkReg("select clears enable", aDiv, 8'h04);
        wr(aDiv, 8'h80);
        idle(2);
        wr(aDiv, 8'h80);
        idle(1);
        wr(aDiv, 8'h02);
        idle(1);
        chkReg("window not restarted", aDiv, 8'h04);
        $display("test divider_protection done");
        // Every division code and its divided clock rate
        for (int c = 0; c < 16; c++) begin
            setDiv(c[3:0]);
            chkReg("divider select", aDiv, {4'h0, c[3:0]});
            idle(520);
            countEnables(512);
            expPulses = (c > 8) ? 2 : (512 >> c);
            chk("enable pulses", expPulses[15:0], cnt[15:0]);
        end
        setDiv(4'h0);
        $display("test division_codes done");
        // PLL factor, enable, reserved bits and lock
        wr(aPll, 8'hdb);
        idle(1);
        chkReg("pll write", aPll, 8'h1a);
        chk("pll factor", 16'h0006, {12'h000, pllFactor});
        chk("pll running", 16'h0001, {15'h0000, pllRunning});
        chk("rc running", 16'h0001, {15'h0000, rcOscRunning});
        pllRefLocked <= 1'b1;
        idle(40);
        chk("lock early", 16'h0000, {15'h0000, pllClockSafe});
        cnt = 0;
        while (pllClockSafe !== 1'b1 && cnt < 200) begin
            idle(1);
            #1;
            cnt++;
        end
        if (cnt >= 200) begin
            nMismatch++;
            $display("MISMATCH lock wait expected 1 seen timeout");
            end_of_test();
        end
        chkReg("pll locked", aPll, 8'h1b);
        pllIsSystemClock <= 1'b1;
        idle(4);
        wr(aPll, 8'h18);
        idle(1);
        rd(aPll);
        chk("pll enable sys", 16'h0002, {8'h00, rdData & 8'h02});
        pllIsSystemClock <= 1'b0;
        idle(4);
        wr(aPll, 8'h18);
        idle(4);
        rd(aPll);
        chk("enable off", 16'h0000, {8'h00, rdData & 8'h02});
        chk("pll stopped", 16'h0000, {15'h0000, pllRunning});
        $display("test pll done");
        // RC frequency select follows the oscillator state
        wr(aCore, 8'hff);
        idle(1);
        chkReg("core rc off", aCore, 8'h1b);
        chk("reset pin disable", 16'h0001, {15'h0000, resetPinDisable});
        rcOscRequested <= 1'b1;
        idle(4);
        wr(aCore, 8'hff);
        idle(1);
        chkReg("core rc on", aCore, 8'h1f);
        chk("rc 1 MHz", 16'h0001, {15'h0000, rcFrequencySelect});
        rcOscRequested <= 1'b0;
        idle(6);
        chk("rc cleared", 16'h0000, {15'h0000, rcFrequencySelect});
        chkReg("core after rc off", aCore, 8'h1b);
        $display("test core_control done");
        // Second reset with both straps clear
        dutReset(1'b0, 1'b0, 8'h21);
        chkReg("trim reset 2", aTrim, 8'h21);
        chkReg("divider reset 2", aDiv, 8'h00);
        chkReg("core reset 2", aCore, 8'h00);
        countEnables(16);
        chk("undivided pulses", 16'h0010, cnt[15:0]);
        $display("test second_reset done");
        end_of_test();
    end

endmodule // test_clock_prescaler_pll_control
